// ==== rtl/ndca_pkg.sv ====
package ndca_pkg;

  // ----------------------------------------------------------------
  // Object classes and attribute numbers
  // ----------------------------------------------------------------
  localparam logic [7:0] CLASS_SUPERVISOR   = 8'h29;
  localparam logic [7:0] CLASS_DRIVE        = 8'h2A;
  localparam logic [7:0] CLASS_ACK_HANDLER  = 8'h2B;
  localparam logic [7:0] CLASS_APPLICATION  = 8'h70;
  localparam logic [15:0] OBJ_INSTANCE_ONE  = 16'h0001;

  localparam logic [7:0] ATTR_FWD_RUN       = 8'h03;
  localparam logic [7:0] ATTR_REV_RUN       = 8'h04;
  localparam logic [7:0] ATTR_CTRL_SEL      = 8'h05;
  localparam logic [7:0] ATTR_CTRL_STATUS   = 8'h0F;

  localparam logic [7:0] ATTR_AT_SPEED      = 8'h03;
  localparam logic [7:0] ATTR_SPEED_SEL     = 8'h04;
  localparam logic [7:0] ATTR_DRIVE_MODE    = 8'h06;
  localparam logic [7:0] ATTR_MEASURED_RPM  = 8'h07;
  localparam logic [7:0] ATTR_TARGET_RPM    = 8'h08;
  localparam logic [7:0] ATTR_SPEED_STATUS  = 8'h1D;

  localparam logic [7:0] ATTR_ACK_WAIT      = 8'h01;
  localparam logic [7:0] ATTR_RETRY_LIMIT   = 8'h02;
  localparam logic [7:0] ATTR_PRODUCER_INST = 8'h03;

  // ----------------------------------------------------------------
  // Control word commands, status decoding, parameter codes
  // ----------------------------------------------------------------
  localparam logic [3:0] CMD_SHUTDOWN       = 4'h6;
  localparam logic [3:0] CMD_DISABLE_OP     = 4'h7;
  localparam logic [3:0] CMD_ENABLE_OP      = 4'hF;
  localparam int         CMD_WIDTH          = 4;

  localparam logic [15:0] STATUS_STATE_MASK = 16'h006F;
  localparam logic [15:0] STATUS_OP_ENABLED = 16'h0027;
  localparam int          STATUS_AT_SPEED_BIT = 10;

  localparam logic [7:0] PARAM_CODE_GET     = 8'h40;
  localparam logic [7:0] PARAM_CODE_SET     = 8'h2B;

  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [7:0]  DRIVE_MODE_VALUE  = 8'h00;
  localparam logic [15:0] ACK_WAIT_RESET    = 16'h0010;
  localparam logic [7:0]  RETRY_LIMIT_RESET = 8'h01;
  localparam logic [15:0] PRODUCER_INSTANCE = 16'h0004;

  localparam int CLK_PERIOD_NS              = 10;
  localparam int ACK_TICK_NS                = 1000000;
  localparam int ACK_TICK_CYCLES            = ACK_TICK_NS / CLK_PERIOD_NS;

endpackage : ndca_pkg

// ==== rtl/ndca_ack_if.sv ====
`timescale 1ns/1ps
interface ndca_ack_if;
  logic [15:0] wait_ms;
  logic [7:0]  retry_limit;
  logic        sent;
  logic        ack;
  logic        resend;
  logic        limit_evt;

  modport cfg (
    output wait_ms,
    output retry_limit,
    output sent,
    output ack,
    input  resend,
    input  limit_evt
  );

  modport handler (
    input  wait_ms,
    input  retry_limit,
    input  sent,
    input  ack,
    output resend,
    output limit_evt
  );
endinterface : ndca_ack_if

// ==== rtl/ndca_ack_handler.sv ====
`timescale 1ns/1ps
module ndca_ack_handler #(
  parameter int CYC_PER_MS = ndca_pkg::ACK_TICK_CYCLES
) (
  input wire logic   clk,
  input wire logic   rst,
  ndca_ack_if.handler ah
);

  logic        waiting;
  logic [31:0] tick_cnt;
  logic [15:0] ms_cnt;
  logic [7:0]  timeouts;
  logic        tick;
  logic        expired;

  assign tick    = waiting && (tick_cnt == 32'(CYC_PER_MS - 1));
  assign expired = tick && (ms_cnt + 16'h0001 >= ah.wait_ms);

  // ----------------------------------------------------------------
  // Acknowledge wait timer
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst || !waiting || tick) begin
      tick_cnt <= 32'h0000_0000;
    end else begin
      tick_cnt <= tick_cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || ah.sent || ah.ack || expired) begin
      ms_cnt <= 16'h0000;
    end else if (tick) begin
      ms_cnt <= ms_cnt + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Retry counting
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      waiting   <= 1'b0;
      timeouts  <= 8'h00;
      ah.resend <= 1'b0;
      ah.limit_evt <= 1'b0;
    end else begin
      ah.resend    <= 1'b0;
      ah.limit_evt <= 1'b0;
      if (ah.ack) begin
        waiting  <= 1'b0;
        timeouts <= 8'h00;
      end else if (ah.sent) begin
        waiting <= 1'b1;
      end else if (expired) begin
        if (timeouts + 8'h01 >= ah.retry_limit) begin
          ah.limit_evt <= 1'b1;
          waiting      <= 1'b0;
          timeouts     <= 8'h00;
        end else begin
          ah.resend <= 1'b1;
          timeouts  <= timeouts + 8'h01;
        end
      end
    end
  end

  a_timeout_outcome: assert property (@(posedge clk) disable iff (rst)
    (expired && !ah.ack && !ah.sent) |=> (ah.resend ^ ah.limit_evt))
    else $error("timeout gave neither resend nor limit event");

  a_resend_needs_wait: assert property (@(posedge clk) disable iff (rst)
    $rose(ah.resend) |-> $past(waiting) && $past(tick))
    else $error("resend without an expired wait");

endmodule : ndca_ack_handler

// ==== rtl/ndca_adapter.sv ====
`timescale 1ns/1ps
module ndca_adapter #(
  parameter int CYC_PER_MS = ndca_pkg::ACK_TICK_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        req_valid,
  input  wire logic        req_set,
  input  wire logic [7:0]  req_class,
  input  wire logic [15:0] req_instance,
  input  wire logic [7:0]  req_attr,
  input  wire logic [15:0] req_wdata,
  output logic             rsp_valid,
  output logic             rsp_error,
  output logic [15:0]      rsp_rdata,
  input  wire logic        local_fwd_pin,
  input  wire logic        local_rev_pin,
  input  wire logic [15:0] local_rpm,
  input  wire logic [15:0] drive_status_word,
  input  wire logic [15:0] drive_measured_rpm,
  input  wire logic [11:0] control_word_upper,
  output logic [15:0]      control_word,
  output logic [15:0]      speed_reference,
  output logic             param_req_valid,
  output logic [7:0]       param_req_code,
  output logic [15:0]      param_index,
  output logic [7:0]       param_subindex,
  output logic [15:0]      param_wdata,
  input  wire logic        param_done,
  input  wire logic        param_error,
  input  wire logic [15:0] param_rdata,
  input  wire logic        io_frame_sent,
  input  wire logic        io_ack_received,
  output logic             io_resend,
  output logic             io_retry_limit,
  output logic [15:0]      ack_event_instance
);

  // ----------------------------------------------------------------
  // Attribute storage and run state
  // ----------------------------------------------------------------
  logic        net_fwd;
  logic        net_rev;
  logic        ctrl_sel;
  logic        speed_sel;
  logic        speed_status;
  logic [15:0] target_rpm;
  logic [15:0] ack_wait_time;
  logic [7:0]  ack_retry_limit;
  logic        eff_fwd;
  logic        eff_rev;
  logic [3:0]  cmd;
  logic        rev_dir;
  logic        fwd_s1;
  logic        fwd_s2;
  logic        rev_s1;
  logic        rev_s2;
  logic        param_busy;
  logic        op_enabled;
  logic        wr_any;
  logic        wr_sup;
  logic        wr_drv;
  logic        wr_ack;
  logic        app_hit;
  logic        next_net_fwd;
  logic        next_net_rev;
  logic        next_fwd;
  logic        next_rev;
  logic [3:0]  next_cmd;
  logic        next_rev_dir;
  logic [15:0] rd_data;
  logic        rd_error;
  logic [15:0] sel_rpm;

  ndca_ack_if ack_bus ();

  assign op_enabled = (drive_status_word & ndca_pkg::STATUS_STATE_MASK)
                      == ndca_pkg::STATUS_OP_ENABLED;
  assign wr_any  = req_valid && req_set && !param_busy
                   && req_instance == ndca_pkg::OBJ_INSTANCE_ONE;
  assign wr_sup  = wr_any && req_class == ndca_pkg::CLASS_SUPERVISOR;
  assign wr_drv  = wr_any && req_class == ndca_pkg::CLASS_DRIVE;
  assign wr_ack  = wr_any && req_class == ndca_pkg::CLASS_ACK_HANDLER;
  assign app_hit = req_valid && !param_busy && req_class == ndca_pkg::CLASS_APPLICATION;

  // ----------------------------------------------------------------
  // Local run switches, two-stage synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      fwd_s1 <= 1'b0;
      fwd_s2 <= 1'b0;
      rev_s1 <= 1'b0;
      rev_s2 <= 1'b0;
    end else begin
      fwd_s1 <= local_fwd_pin;
      fwd_s2 <= fwd_s1;
      rev_s1 <= local_rev_pin;
      rev_s2 <= rev_s1;
    end
  end

  // ----------------------------------------------------------------
  // Writable attributes
  // ----------------------------------------------------------------
  assign next_net_fwd = (wr_sup && req_attr == ndca_pkg::ATTR_FWD_RUN) ? req_wdata[0] : net_fwd;
  assign next_net_rev = (wr_sup && req_attr == ndca_pkg::ATTR_REV_RUN) ? req_wdata[0] : net_rev;

  always_ff @(posedge clk) begin
    if (rst) begin
      net_fwd  <= 1'b0;
      net_rev  <= 1'b0;
      ctrl_sel <= 1'b0;
    end else begin
      net_fwd <= next_net_fwd;
      net_rev <= next_net_rev;
      if (wr_sup && req_attr == ndca_pkg::ATTR_CTRL_SEL) begin
        ctrl_sel <= req_wdata[0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      speed_sel    <= 1'b0;
      speed_status <= 1'b0;
      target_rpm   <= 16'h0000;
    end else begin
      speed_status <= speed_sel;
      if (wr_drv && req_attr == ndca_pkg::ATTR_SPEED_SEL) begin
        speed_sel <= req_wdata[0];
      end
      if (wr_drv && req_attr == ndca_pkg::ATTR_TARGET_RPM) begin
        target_rpm <= req_wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ack_wait_time   <= ndca_pkg::ACK_WAIT_RESET;
      ack_retry_limit <= ndca_pkg::RETRY_LIMIT_RESET;
    end else begin
      if (wr_ack && req_attr == ndca_pkg::ATTR_ACK_WAIT) begin
        ack_wait_time <= req_wdata;
      end
      if (wr_ack && req_attr == ndca_pkg::ATTR_RETRY_LIMIT) begin
        ack_retry_limit <= req_wdata[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Run and stop event decoding
  // ----------------------------------------------------------------
  always_comb begin
    next_fwd     = ctrl_sel ? next_net_fwd : fwd_s2;
    next_rev     = ctrl_sel ? next_net_rev : rev_s2;
    next_cmd     = cmd;
    next_rev_dir = rev_dir;
    if (!next_fwd && !next_rev) begin
      next_cmd = op_enabled ? ndca_pkg::CMD_DISABLE_OP : ndca_pkg::CMD_SHUTDOWN;
    end else if (next_fwd && !next_rev && (!eff_fwd || eff_rev)) begin
      next_cmd     = ndca_pkg::CMD_ENABLE_OP;
      next_rev_dir = 1'b0;
    end else if (!next_fwd && next_rev && (!eff_rev || eff_fwd)) begin
      next_cmd     = ndca_pkg::CMD_ENABLE_OP;
      next_rev_dir = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      eff_fwd <= 1'b0;
      eff_rev <= 1'b0;
      cmd     <= ndca_pkg::CMD_SHUTDOWN;
      rev_dir <= 1'b0;
    end else begin
      eff_fwd <= next_fwd;
      eff_rev <= next_rev;
      cmd     <= next_cmd;
      rev_dir <= next_rev_dir;
    end
  end

  // ----------------------------------------------------------------
  // Control word and speed reference
  // ----------------------------------------------------------------
  assign sel_rpm = speed_sel ? target_rpm : local_rpm;

  always_ff @(posedge clk) begin
    if (rst) begin
      control_word    <= {12'h000, ndca_pkg::CMD_SHUTDOWN};
      speed_reference <= 16'h0000;
    end else begin
      control_word    <= {control_word_upper, cmd};
      speed_reference <= rev_dir ? 16'(-sel_rpm) : sel_rpm;
    end
  end

  // ----------------------------------------------------------------
  // Attribute reads
  // ----------------------------------------------------------------
  always_comb begin
    rd_data  = 16'h0000;
    rd_error = 1'b0;
    if (req_instance != ndca_pkg::OBJ_INSTANCE_ONE) begin
      rd_error = 1'b1;
    end else if (req_class == ndca_pkg::CLASS_SUPERVISOR) begin
      case (req_attr)
        ndca_pkg::ATTR_FWD_RUN:     rd_data = {15'h0000, net_fwd};
        ndca_pkg::ATTR_REV_RUN:     rd_data = {15'h0000, net_rev};
        ndca_pkg::ATTR_CTRL_SEL:    rd_data = {15'h0000, ctrl_sel};
        ndca_pkg::ATTR_CTRL_STATUS: rd_data = {15'h0000, ctrl_sel};
        default:                    rd_error = 1'b1;
      endcase
      if (req_set && req_attr == ndca_pkg::ATTR_CTRL_STATUS) begin
        rd_error = 1'b1;
      end
    end else if (req_class == ndca_pkg::CLASS_DRIVE) begin
      case (req_attr)
        ndca_pkg::ATTR_AT_SPEED:     rd_data = {15'h0000, drive_status_word[ndca_pkg::STATUS_AT_SPEED_BIT]};
        ndca_pkg::ATTR_SPEED_SEL:    rd_data = {15'h0000, speed_sel};
        ndca_pkg::ATTR_DRIVE_MODE:   rd_data = {8'h00, ndca_pkg::DRIVE_MODE_VALUE};
        ndca_pkg::ATTR_MEASURED_RPM: rd_data = drive_measured_rpm;
        ndca_pkg::ATTR_TARGET_RPM:   rd_data = target_rpm;
        ndca_pkg::ATTR_SPEED_STATUS: rd_data = {15'h0000, speed_status};
        default:                     rd_error = 1'b1;
      endcase
      if (req_set && req_attr != ndca_pkg::ATTR_SPEED_SEL
          && req_attr != ndca_pkg::ATTR_TARGET_RPM) begin
        rd_error = 1'b1;
      end
    end else if (req_class == ndca_pkg::CLASS_ACK_HANDLER) begin
      case (req_attr)
        ndca_pkg::ATTR_ACK_WAIT:      rd_data = ack_wait_time;
        ndca_pkg::ATTR_RETRY_LIMIT:   rd_data = {8'h00, ack_retry_limit};
        ndca_pkg::ATTR_PRODUCER_INST: rd_data = ndca_pkg::PRODUCER_INSTANCE;
        default:                      rd_error = 1'b1;
      endcase
      if (req_set && req_attr == ndca_pkg::ATTR_PRODUCER_INST) begin
        rd_error = 1'b1;
      end
    end else begin
      rd_error = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Parameter request translation and answers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      param_req_valid <= 1'b0;
      param_req_code  <= 8'h00;
      param_index     <= 16'h0000;
      param_subindex  <= 8'h00;
      param_wdata     <= 16'h0000;
      param_busy      <= 1'b0;
    end else begin
      param_req_valid <= app_hit;
      if (app_hit) begin
        param_req_code <= req_set ? ndca_pkg::PARAM_CODE_SET : ndca_pkg::PARAM_CODE_GET;
        param_index    <= req_instance;
        param_subindex <= req_attr;
        param_wdata    <= req_wdata;
        param_busy     <= 1'b1;
      end else if (param_done) begin
        param_busy <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rsp_valid <= 1'b0;
      rsp_error <= 1'b0;
      rsp_rdata <= 16'h0000;
    end else begin
      rsp_valid <= 1'b0;
      rsp_error <= 1'b0;
      if (param_busy && param_done) begin
        rsp_valid <= 1'b1;
        rsp_error <= param_error;
        rsp_rdata <= param_rdata;
      end else if (req_valid && param_busy) begin
        rsp_valid <= 1'b1;
        rsp_error <= 1'b1;
      end else if (req_valid && !app_hit) begin
        rsp_valid <= 1'b1;
        rsp_error <= rd_error;
        rsp_rdata <= rd_data;
      end
    end
  end

  // ----------------------------------------------------------------
  // Acknowledge handler
  // ----------------------------------------------------------------
  assign ack_bus.wait_ms     = ack_wait_time;
  assign ack_bus.retry_limit = ack_retry_limit;
  assign ack_bus.sent        = io_frame_sent;
  assign ack_bus.ack         = io_ack_received;
  assign io_resend           = ack_bus.resend;
  assign io_retry_limit      = ack_bus.limit_evt;
  assign ack_event_instance  = ndca_pkg::PRODUCER_INSTANCE;

  ndca_ack_handler #(
    .CYC_PER_MS (CYC_PER_MS)
  ) u_ack (
    .clk (clk),
    .rst (rst),
    .ah  (ack_bus)
  );

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_fwd_rise;
    !eff_fwd && next_fwd && !next_rev;
  endsequence

  sequence s_rev_rise;
    !eff_rev && next_rev && !next_fwd;
  endsequence

  sequence s_param_get;
    app_hit && !req_set;
  endsequence

  a_stop_shutdown: assert property (@(posedge clk) disable iff (rst)
    (!next_fwd && !next_rev && !op_enabled) |=> ##1 control_word[3:0] == 4'h6)
    else $error("stop outside operation enabled did not give shutdown");

  a_stop_disable: assert property (@(posedge clk) disable iff (rst)
    (!next_fwd && !next_rev && op_enabled) |=> cmd == 4'h7)
    else $error("stop in operation enabled did not give disable");

  a_fwd_enable: assert property (@(posedge clk) disable iff (rst)
    s_fwd_rise |=> cmd == 4'hF && !rev_dir ##1 control_word[3:0] == 4'hF)
    else $error("forward rise did not enable forward");

  a_rev_enable: assert property (@(posedge clk) disable iff (rst)
    s_rev_rise |=> cmd == 4'hF && rev_dir)
    else $error("reverse rise did not enable reverse");

  a_both_hold: assert property (@(posedge clk) disable iff (rst)
    (next_fwd && next_rev) |=> $stable(cmd) && $stable(rev_dir))
    else $error("both requests high changed the command");

  a_fall_to_rev: assert property (@(posedge clk) disable iff (rst)
    (eff_fwd && eff_rev && !next_fwd && next_rev && !speed_sel)
      |=> rev_dir ##1 speed_reference == 16'(-$past(local_rpm)))
    else $error("forward fall did not reverse the speed reference");

  a_upper_pass: assert property (@(posedge clk) disable iff (rst)
    1'b1 |=> control_word[15:4] == $past(control_word_upper))
    else $error("control word upper bits altered");

  a_get_code: assert property (@(posedge clk) disable iff (rst)
    s_param_get |=> param_req_valid && param_req_code == 8'h40
      && param_index == $past(req_instance) && param_subindex == $past(req_attr))
    else $error("get request not translated to code 0x40");

  a_set_code: assert property (@(posedge clk) disable iff (rst)
    (app_hit && req_set) |=> param_req_code == 8'h2B)
    else $error("set request not translated to code 0x2B");

  a_mode_read: assert property (@(posedge clk) disable iff (rst)
    (req_valid && !req_set && !param_busy && req_class == 8'h2A
      && req_instance == 16'h0001 && req_attr == 8'h06)
      |=> rsp_valid && !rsp_error && rsp_rdata == 16'h0000)
    else $error("drive mode did not read zero");

endmodule : ndca_adapter

// ==== tb/ndca_drive_model.sv ====
`timescale 1ns/1ps
module ndca_drive_model (
  input  wire logic        clk,
  input  wire logic        op_en,
  input  wire logic        param_req_valid,
  input  wire logic [15:0] param_index,
  output logic             param_done,
  output logic             param_error,
  output logic [15:0]      param_rdata,
  output logic [15:0]      drive_status_word
);
  logic [1:0] cnt  = 2'h0;
  logic       busy = 1'b0;
  initial param_done = 1'b0;
  initial param_rdata = 16'h0000;
  // Operation enabled at speed, or ready to switch on
  assign drive_status_word = op_en ? 16'h0427 : 16'h0021;
  assign param_error = 1'b0;
  always @(posedge clk) begin
    param_done <= 1'b0;
    param_rdata <= ~param_rdata;
    cnt <= busy ? cnt + 2'h1 : 2'h0;
    if (param_req_valid) begin
      busy <= 1'b1;
    end else if (busy && cnt == 2'h2) begin
      busy <= 1'b0;
      param_done <= 1'b1;
      param_rdata <= param_index ^ 16'h5A00;
    end
  end
endmodule : ndca_drive_model

// ==== tb/network_drive_command_adapter_test.sv ====
`timescale 1ns/1ps
module network_drive_command_adapter_test;
  localparam logic [7:0] CS = ndca_pkg::CLASS_SUPERVISOR;
  localparam logic [7:0] DR = ndca_pkg::CLASS_DRIVE;
  localparam logic [7:0] AK = ndca_pkg::CLASS_ACK_HANDLER;
  logic clk = 1'b0, rst = 1'b1, req_valid = 1'b0, req_set = 1'b0, op_en = 1'b0;
  logic [7:0] req_class = 8'h00, req_attr = 8'h00, p_code, p_sub;
  logic [15:0] req_instance = 16'h0000, req_wdata = 16'h0000, rd, p_idx, p_wd;
  logic rsp_valid, rsp_error, er, param_req_valid, param_done, param_error;
  logic io_frame_sent = 1'b0, io_resend, io_retry_limit;
  logic local_fwd_pin = 1'b0, local_rev_pin = 1'b0, io_ack_received = 1'b0;
  int resends = 0, limits = 0;
  logic [7:0] param_req_code, param_subindex;
  logic [15:0] rsp_rdata, control_word, speed_reference, param_index, param_wdata;
  logic [15:0] param_rdata, drive_status_word, ack_event_instance;
  int failures = 0, checked = 0;
  ndca_adapter #(.CYC_PER_MS(4)) u_dut (.clk(clk), .rst(rst), .req_valid(req_valid),
    .req_set(req_set), .req_class(req_class), .req_instance(req_instance),
    .req_attr(req_attr), .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_error(rsp_error),
    .rsp_rdata(rsp_rdata), .local_fwd_pin(local_fwd_pin), .local_rev_pin(local_rev_pin),
    .local_rpm(16'h0055),
    .drive_status_word(drive_status_word), .drive_measured_rpm(16'hFC18),
    .control_word_upper(12'hA5C), .control_word(control_word),
    .speed_reference(speed_reference), .param_req_valid(param_req_valid),
    .param_req_code(param_req_code), .param_index(param_index),
    .param_subindex(param_subindex), .param_wdata(param_wdata), .param_done(param_done),
    .param_error(param_error), .param_rdata(param_rdata), .io_frame_sent(io_frame_sent),
    .io_ack_received(io_ack_received), .io_resend(io_resend), .io_retry_limit(io_retry_limit),
    .ack_event_instance(ack_event_instance));
  ndca_drive_model u_drive (.clk(clk), .op_en(op_en), .param_req_valid(param_req_valid),
    .param_index(param_index), .param_done(param_done), .param_error(param_error),
    .param_rdata(param_rdata), .drive_status_word(drive_status_word));
  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    if (io_resend === 1'b1) resends++;
    if (io_retry_limit === 1'b1) limits++;
  end
  always @(posedge clk) if (param_req_valid === 1'b1)
    {p_code, p_idx, p_sub, p_wd} <= {param_req_code, param_index, param_subindex, param_wdata};
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic req(input logic st, input logic [7:0] cl, input logic [15:0] inst,
                     input logic [7:0] at, input logic [15:0] wd);
    int n;
    n = 0;
    {req_valid, req_set, req_class, req_instance, req_attr, req_wdata} <= {1'b1, st, cl, inst, at, wd};
    @(posedge clk);
    req_valid <= 1'b0;
    do begin
      @(negedge clk);
      n++;
    end while (rsp_valid !== 1'b1 && n < 50);
    if (n >= 50) check("rsp_valid", 16'h0000, 16'h0001);
    {rd, er} = {rsp_rdata, rsp_error};
    @(posedge clk);
  endtask : req
  task automatic wr_run(input logic [7:0] at, input logic v, input logic [15:0] cw,
                        input logic [15:0] spd);
    req(1'b1, CS, 16'h0001, at, {15'h0000, v});
    repeat (4) @(posedge clk);
    check("control_word", control_word, cw);
    check("speed_reference", speed_reference, spd);
  endtask : wr_run
  task automatic t_run();
    check("cw after reset", control_word, 16'hA5C6);
    req(1'b1, CS, 16'h0001, ndca_pkg::ATTR_CTRL_SEL, 16'h0001);
    req(1'b1, DR, 16'h0001, ndca_pkg::ATTR_SPEED_SEL, 16'h0001);
    req(1'b1, DR, 16'h0001, ndca_pkg::ATTR_TARGET_RPM, 16'h0064);
    wr_run(ndca_pkg::ATTR_FWD_RUN, 1'b1, 16'hA5CF, 16'h0064);
    wr_run(ndca_pkg::ATTR_REV_RUN, 1'b1, 16'hA5CF, 16'h0064);
    wr_run(ndca_pkg::ATTR_FWD_RUN, 1'b0, 16'hA5CF, 16'hFF9C);
    wr_run(ndca_pkg::ATTR_FWD_RUN, 1'b1, 16'hA5CF, 16'hFF9C);
    wr_run(ndca_pkg::ATTR_REV_RUN, 1'b0, 16'hA5CF, 16'h0064);
    op_en <= 1'b1;
    wr_run(ndca_pkg::ATTR_FWD_RUN, 1'b0, 16'hA5C7, 16'h0064);
    op_en <= 1'b0;
    repeat (4) @(posedge clk);
    check("cw stop", control_word, 16'hA5C6);
    wr_run(ndca_pkg::ATTR_REV_RUN, 1'b1, 16'hA5CF, 16'hFF9C);
    $display("t_run done");
  endtask : t_run
  task automatic t_regs();
    req(1'b0, DR, 16'h0001, ndca_pkg::ATTR_SPEED_STATUS, 16'h0000);
    check("speed status", rd, 16'h0001);
    req(1'b0, DR, 16'h0001, ndca_pkg::ATTR_AT_SPEED, 16'h0000);
    check("at speed", rd, 16'h0000);
    req(1'b0, DR, 16'h0001, ndca_pkg::ATTR_MEASURED_RPM, 16'h0000);
    check("measured", rd, 16'hFC18);
    req(1'b1, DR, 16'h0001, ndca_pkg::ATTR_DRIVE_MODE, 16'h0005);
    check("mode set error", {15'h0000, er}, 16'h0001);
    req(1'b0, DR, 16'h0001, ndca_pkg::ATTR_DRIVE_MODE, 16'h0000);
    check("mode", rd, 16'h0000);
    req(1'b0, AK, 16'h0001, ndca_pkg::ATTR_ACK_WAIT, 16'h0000);
    check("ack wait", rd, 16'h0010);
    req(1'b0, AK, 16'h0001, ndca_pkg::ATTR_RETRY_LIMIT, 16'h0000);
    check("retry limit", rd, 16'h0001);
    req(1'b0, AK, 16'h0001, ndca_pkg::ATTR_PRODUCER_INST, 16'h0000);
    check("producer", rd, 16'h0004);
    check("event inst", ack_event_instance, 16'h0004);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_param();
    req(1'b0, ndca_pkg::CLASS_APPLICATION, 16'h0005, 8'h02, 16'h0000);
    check("get code", {8'h00, p_code}, 16'h0040);
    check("get index", p_idx, 16'h0005);
    check("get sub", {8'h00, p_sub}, 16'h0002);
    check("get data", rd, 16'h5A05);
    req(1'b1, ndca_pkg::CLASS_APPLICATION, 16'h0009, 8'h01, 16'h1234);
    check("set code", {8'h00, p_code}, 16'h002B);
    check("set fields", p_idx ^ p_wd, 16'h123D);
    $display("t_param done");
  endtask : t_param
  task automatic t_local();
    req(1'b1, CS, 16'h0001, ndca_pkg::ATTR_CTRL_SEL, 16'h0000);
    req(1'b1, DR, 16'h0001, ndca_pkg::ATTR_SPEED_SEL, 16'h0000);
    {local_fwd_pin, local_rev_pin} <= 2'b11;
    repeat (6) @(posedge clk);
    check("cw both rise", control_word, 16'hA5C6);
    local_fwd_pin <= 1'b0;
    repeat (6) @(posedge clk);
    check("cw local rev", control_word, 16'hA5CF);
    check("speed local rev", speed_reference, 16'hFFAB);
    wr_run(ndca_pkg::ATTR_FWD_RUN, 1'b1, 16'hA5CF, 16'hFFAB);
    local_rev_pin <= 1'b0;
    repeat (6) @(posedge clk);
    check("cw local stop", control_word, 16'hA5C6);
    $display("t_local done");
  endtask : t_local
  task automatic t_ack();
    int n;
    n = 0;
    io_frame_sent <= 1'b1;
    @(posedge clk);
    io_frame_sent <= 1'b0;
    do begin
      @(negedge clk);
      n++;
    end while (io_retry_limit !== 1'b1 && n < 200);
    check("ack wait cycles", {15'h0000, n >= 64 && n <= 67}, 16'h0001);
    @(posedge clk);
    req(1'b1, AK, 16'h0001, ndca_pkg::ATTR_RETRY_LIMIT, 16'h0002);
    req(1'b1, AK, 16'h0001, ndca_pkg::ATTR_ACK_WAIT, 16'h0002);
    n = 0;
    io_frame_sent <= 1'b1;
    @(posedge clk);
    io_frame_sent <= 1'b0;
    do begin
      @(negedge clk);
      n++;
    end while (io_resend !== 1'b1 && n < 50);
    check("resend cycle", 16'(n), 16'h0009);
    do begin
      @(negedge clk);
      n++;
    end while (io_retry_limit !== 1'b1 && n < 50);
    check("limit cycle", 16'(n), 16'h0011);
    @(posedge clk);
    io_frame_sent <= 1'b1;
    @(posedge clk);
    io_frame_sent <= 1'b0;
    repeat (4) @(posedge clk);
    io_ack_received <= 1'b1;
    @(posedge clk);
    io_ack_received <= 1'b0;
    repeat (20) @(posedge clk);
    check("resend count", 16'(resends), 16'h0001);
    check("limit count", 16'(limits), 16'h0002);
    $display("t_ack done");
  endtask : t_ack
  task automatic close_out();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    close_out();
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    t_run();
    t_regs();
    t_param();
    t_local();
    t_ack();
    close_out();
  end
endmodule : network_drive_command_adapter_test
